// File: hdl/adcscp_pkg.sv
// Constants for the converter serial control and result port.
// Assumes a 25 MHz core clock and a host-driven shift clock.
// Function
// - Result output high impedance while select high, driven while select low.
// - On select low, drive first result bit immediately, in programmed order.
// - Each later falling shift edge advances the output to the next bit.
// - Remaining eleven bits follow, changing only on falling shift edges.
// - Conversion-done goes low after the last falling shift edge of a frame.
// - Conversion-done stays low until the new result is ready, then high.
// - Eight command bits captured, one per each of first eight rising edges.
// - Input-select address usable once the fourth rising edge has occurred.
// - Sampling starts on fourth falling edge, lasts to last falling edge.
// - Last falling edge hands the conversion to the internal state machine.
// - Select falling resets frame counters and enables output and inputs.
// - Select rising disables command input and shift clock.
// - Control inputs ignored for 1.425 us after select falls.
package adcscp_pkg;
    localparam int CLK_NS       = 40;
    localparam int SETUP_NS     = 1425;
    localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_NS      = 10000;
    localparam int CONV_CYC     = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int RES_BITS     = 12;
    localparam int CMD_BITS     = 8;
    localparam int ADDR_BITS    = 4;
    localparam int ADDR_RISE    = 4;
    localparam int SAMPLE_FALL  = 4;
    localparam int FRAME_CLOCKS = 12;
    localparam int LSBF_POS     = 1;
    localparam int CNT_W        = 4;
    localparam int TIM_W        = 9;
    localparam logic [11:0] RES_RESET = 12'h000;
endpackage : adcscp_pkg

// File: hdl/adcscp_sync.sv
// Two-flop synchroniser for level signals.
// Assumes inputs are levels or toggles from another domain.
`timescale 1ns/100ps
module adcscp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } adcscp_sync_type;

    adcscp_sync_type st;
    adcscp_sync_type next_st;

    always_comb begin
        // Stages hold the input relative to its reset value, so reset is all ones
        next_st.stage1 = async_in ^ ~reset_val;
        next_st.stage2 = st.stage1;
    end

    // Reset value is a tied constant at every instance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    // Reads back as reset_val in reset: no false edge once reset lets go
    assign sync_out = st.stage2 ^ ~reset_val;
endmodule : adcscp_sync

// File: hdl/adcscp_top.sv
// Serial control and result port of a 12-bit converter.
// Assumes host drives select_n, sclk and cmd_in; converter supplies conv_data.
`timescale 1ns/100ps
module adcscp_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        select_n,
    input  wire logic        cmd_in,
    input  wire logic [11:0] conv_data,
    output logic             dout,
    output logic             dout_oe,
    output logic             eoc,
    output logic [3:0]       mux_addr,
    output logic             mux_addr_valid,
    output logic             sampling
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [adcscp_pkg::CNT_W-1:0]    rise_cnt;
        logic [adcscp_pkg::CMD_BITS-1:0]  cmd;
        logic [adcscp_pkg::ADDR_BITS-1:0] addr;
        logic                             addr_valid;
    } adcscp_rise_type;

    typedef struct packed {
        logic [adcscp_pkg::CNT_W-1:0] fall_cnt;
        logic                         sampling;
    } adcscp_fall_type;

    typedef struct packed {
        logic                            toggle;
        logic [adcscp_pkg::CMD_BITS-1:0] cmd;
    } adcscp_hand_type;

    typedef enum logic [1:0] {
        ADCSCP_IDLE = 2'b00,
        ADCSCP_CONV = 2'b01,
        ADCSCP_DONE = 2'b10
    } adcscp_state_type;

    typedef struct packed {
        adcscp_state_type                    state;
        logic [adcscp_pkg::TIM_W-1:0]        setup_cnt;
        logic                                setup_ok;
        logic                                tog_seen;
        logic [adcscp_pkg::TIM_W-1:0]        conv_cnt;
        logic                                eoc;
        logic [adcscp_pkg::RES_BITS-1:0]     out_word;
    } adcscp_core_type;

    adcscp_rise_type  rs;
    adcscp_rise_type  next_rs;
    adcscp_fall_type  fs;
    adcscp_fall_type  next_fs;
    adcscp_hand_type  hs;
    adcscp_hand_type  next_hs;
    adcscp_core_type  cs;
    adcscp_core_type  next_cs;
    logic             frame_rst_n;
    logic [1:0]       synced;
    logic             sel_n_s;
    logic             tog_s;

    assign frame_rst_n = rst_n & ~select_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Rising shift edges: command capture
    always_comb begin
        next_rs = rs;
        // ignore until setup elapsed
        // Setup flag is quasi-static: host waits out setup before first edge
        if (cs.setup_ok && rs.rise_cnt != adcscp_pkg::CNT_W'(adcscp_pkg::CMD_BITS)) begin
            next_rs.cmd      = {rs.cmd[adcscp_pkg::CMD_BITS-2:0], cmd_in};
            next_rs.rise_cnt = rs.rise_cnt + 1'b1;
            if (next_rs.rise_cnt == adcscp_pkg::CNT_W'(adcscp_pkg::ADDR_RISE)) begin
                // Held apart: later command bits must not move the mux mid-sample
                next_rs.addr       = next_rs.cmd[adcscp_pkg::ADDR_BITS-1:0];
                next_rs.addr_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rs <= '0;
        end else begin
            rs <= next_rs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Falling shift edges: output index and sampling window
    always_comb begin
        next_fs = fs;
        if (cs.setup_ok && fs.fall_cnt != adcscp_pkg::CNT_W'(adcscp_pkg::FRAME_CLOCKS)) begin
            next_fs.fall_cnt = fs.fall_cnt + 1'b1;
            if (next_fs.fall_cnt == adcscp_pkg::CNT_W'(adcscp_pkg::SAMPLE_FALL)) begin
                next_fs.sampling = 1'b1;
            end
            if (next_fs.fall_cnt == adcscp_pkg::CNT_W'(adcscp_pkg::FRAME_CLOCKS)) begin
                next_fs.sampling = 1'b0;
            end
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fs <= '0;
        end else begin
            fs <= next_fs;
        end
    end

    // Survives select rising so the core can read the command afterwards
    always_comb begin
        next_hs = hs;
        if (fs.fall_cnt == adcscp_pkg::CNT_W'(adcscp_pkg::FRAME_CLOCKS - 1)) begin
            next_hs.toggle = ~hs.toggle;
            next_hs.cmd    = rs.cmd;
        end
    end

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            hs <= '0;
        end else begin
            hs <= next_hs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings into the core clock
    adcscp_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({select_n, hs.toggle}),
        .reset_val(2'h2),
        .sync_out (synced)
    );

    assign sel_n_s = synced[1];
    assign tog_s   = synced[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Core: setup timer and conversion sequencer
    always_comb begin
        next_cs = cs;
        if (sel_n_s) begin
            next_cs.setup_cnt = '0;
            next_cs.setup_ok  = 1'b0;
        end else if (cs.setup_cnt != adcscp_pkg::TIM_W'(adcscp_pkg::SETUP_CYC)) begin
            next_cs.setup_cnt = cs.setup_cnt + 1'b1;
        end else begin
            next_cs.setup_ok = 1'b1;
        end
        next_cs.tog_seen = tog_s;
        case (cs.state)
            ADCSCP_IDLE: begin
                if (tog_s != cs.tog_seen) begin
                    next_cs.eoc      = 1'b0;
                    next_cs.conv_cnt = '0;
                    next_cs.state    = ADCSCP_CONV;
                end
            end
            ADCSCP_CONV: begin
                if (cs.conv_cnt == adcscp_pkg::TIM_W'(adcscp_pkg::CONV_CYC - 1)) begin
                    next_cs.state = ADCSCP_DONE;
                end else begin
                    next_cs.conv_cnt = cs.conv_cnt + 1'b1;
                end
            end
            ADCSCP_DONE: begin
                for (int i = 0; i < adcscp_pkg::RES_BITS; i++) begin
                    if (hs.cmd[adcscp_pkg::LSBF_POS]) begin
                        next_cs.out_word[i] = conv_data[i];
                    end else begin
                        next_cs.out_word[i] = conv_data[adcscp_pkg::RES_BITS - 1 - i];
                    end
                end
                next_cs.eoc   = 1'b1;
                next_cs.state = ADCSCP_IDLE;
            end
            default: begin
                next_cs.state = ADCSCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs          <= '0;
            cs.eoc      <= 1'b1;
            cs.tog_seen <= 1'b0;
            cs.out_word <= adcscp_pkg::RES_RESET;
        end else begin
            cs <= next_cs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive; result word is stable while a frame runs
    // enable follows select
    assign dout_oe = ~select_n;
    assign dout = (fs.fall_cnt < adcscp_pkg::CNT_W'(adcscp_pkg::RES_BITS)) ?
                  cs.out_word[fs.fall_cnt] : 1'b0;
    assign eoc            = cs.eoc;
    assign mux_addr       = rs.addr;
    assign mux_addr_valid = rs.addr_valid;
    assign sampling       = fs.sampling;
endmodule : adcscp_top

// File: verif/adcscp_asserts.sv
// Port checker for the converter serial port.
// Assumes host frames of 12 shift clocks with no early pulses.
`timescale 1ns/100ps
module adcscp_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sclk,
    input wire logic        select_n,
    input wire logic        cmd_in,
    input wire logic [11:0] conv_data,
    input wire logic        dout,
    input wire logic        dout_oe,
    input wire logic        eoc,
    input wire logic [3:0]  mux_addr,
    input wire logic        mux_addr_valid,
    input wire logic        sampling
);
    logic [3:0] rise_cnt, fall_cnt, addr_sh;
    logic [8:0] low_cnt;
    always_ff @(posedge sclk or posedge select_n) begin
        if (select_n) begin
            rise_cnt <= 4'h0;
            addr_sh  <= 4'h0;
        end else if (rise_cnt != 4'hf) begin
            rise_cnt <= rise_cnt + 4'h1;
            if (rise_cnt < 4'h4) addr_sh <= {addr_sh[2:0], cmd_in};
        end
    end
    always_ff @(negedge sclk or posedge select_n) begin
        if (select_n) fall_cnt <= 4'h0;
        else if (fall_cnt != 4'hf) fall_cnt <= fall_cnt + 4'h1;
    end
    // Low time of the done flag, in core cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 9'h000;
        else low_cnt <= eoc ? 9'h000 : low_cnt + 9'h001;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_oe_follows_sel: assert property (@(posedge clk) dout_oe == !select_n)
        else $error("output enable not tied to select");
    a_dout_only_fall: assert property (@(posedge clk) disable iff (!rst_n)
        !select_n && !$past(select_n) && sclk && $past(sclk) |-> $stable(dout))
        else $error("result bit moved while shift clock high");
    a_addr_valid_four: assert property (@(negedge sclk) disable iff (select_n)
        mux_addr_valid == (rise_cnt >= 4'h4)) else $error("address valid misplaced");
    a_addr_value: assert property (@(negedge sclk) disable iff (select_n)
        rise_cnt >= 4'h4 |-> mux_addr == addr_sh) else $error("address bits wrong");
    a_sample_window: assert property (@(negedge sclk) disable iff (select_n)
        sampling == (fall_cnt >= 4'h4 && fall_cnt < 4'hc)) else $error("sampling window wrong");
    a_eoc_after_frame: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sampling) && !select_n |-> ##[1:6] !eoc) else $error("done flag did not fall");
    a_eoc_low_time: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(eoc) |-> low_cnt inside {[248:254]}) else $error("conversion time wrong");
    a_idle_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        select_n |-> !sampling && !mux_addr_valid) else $error("frame state left set");
    c_eoc_rise: cover property (@(posedge clk) $rose(eoc));
    c_addr_valid: cover property (@(posedge clk) $rose(mux_addr_valid));
    c_sample_end: cover property (@(posedge clk) $fell(sampling));
endmodule : adcscp_asserts
bind adcscp_top adcscp_asserts u_asserts (.clk, .rst_n, .sclk, .select_n, .cmd_in,
    .conv_data, .dout, .dout_oe, .eoc, .mux_addr, .mux_addr_valid, .sampling);

// File: verif/adcscp_host.sv
// Host serial port model: select, shift clock, command bits.
// Assumes a 160 ns shift clock, held low between frames.
`timescale 1ns/100ps
module adcscp_host (
    output logic      sclk,
    output logic      select_n,
    output logic      cmd_in,
    input  wire logic dout,
    input  wire logic dout_oe
);
    initial begin
        sclk = 1'b0;
        select_n <= 1'b1;
        cmd_in = 1'b0;
    end
    task automatic frame(input logic [7:0] cmd, output logic [11:0] got);
        // Called on a core clock edge, so select moves like any clocked input
        select_n <= 1'b0;
        // setup plus sync margin; odd delay keeps shift edges off core edges
        #1707;
        for (int i = 0; i < 12; i++) begin
            cmd_in = (i < 8) ? cmd[7-i] : ~cmd_in;
            #40 sclk = 1'b1;
            got[11-i] = dout_oe ? dout : 1'bx;
            #80 sclk = 1'b0;
            #40;
        end
        #80 select_n <= 1'b1;
        // Released line must not keep its value
        cmd_in = ~cmd_in;
    endtask : frame
endmodule : adcscp_host

// File: verif/tb_adc_serial_control_port.sv
// Testbench for the converter serial port.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps
module tb_adc_serial_control_port;
    logic        clk, rst_n, sclk, select_n, cmd_in, dout, dout_oe, eoc;
    logic        mux_addr_valid, sampling;
    logic [11:0] conv_data;
    logic [3:0]  mux_addr;
    int          bad_count = 0;
    int          compares = 0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    adcscp_top u_dut (.clk, .rst_n, .sclk, .select_n, .cmd_in, .conv_data, .dout,
        .dout_oe, .eoc, .mux_addr, .mux_addr_valid, .sampling);
    adcscp_host u_host (.sclk, .select_n, .cmd_in, .dout, .dout_oe);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check12(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check12
    task automatic check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic wait_eoc(input logic lvl);
        int n;
        n = 0;
        while (eoc !== lvl && n < 400) begin
            @(posedge clk);
            n++;
        end
        check_bit("eoc", lvl, eoc);
        if (n >= 400) finish_test();
    endtask : wait_eoc
    task automatic run_frame(input logic [7:0] cmd, input logic [11:0] data,
                             input logic [11:0] exp);
        logic [11:0] got;
        @(posedge clk);
        conv_data <= data;
        u_host.frame(cmd, got);
        check12("result", exp, got);
        wait_eoc(1'b0);
        wait_eoc(1'b1);
    endtask : run_frame
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_idle;
        // A false handover after reset would drop the done flag here
        repeat (8) @(posedge clk);
        check_bit("eoc", 1'b1, eoc);
        check_bit("dout_oe", 1'b0, dout_oe);
        $display("reset idle done");
    endtask : test_reset_idle
    task automatic test_first_result;
        run_frame(8'h50, 12'ha5c, 12'h000);
        $display("first result done");
    endtask : test_first_result
    task automatic test_lsb_command;
        run_frame(8'h32, 12'h3c1, 12'ha5c);
        $display("lsb command done");
    endtask : test_lsb_command
    task automatic test_lsb_output;
        run_frame(8'hb0, 12'h5a0, 12'h83c);
        $display("lsb output done");
    endtask : test_lsb_output
    task automatic test_idle_release;
        @(posedge clk);
        check_bit("dout_oe", 1'b0, dout_oe);
        check_bit("eoc", 1'b1, eoc);
        $display("idle release done");
    endtask : test_idle_release
    initial begin
        rst_n = 1'b0;
        conv_data = 12'h000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        test_reset_idle();
        test_first_result();
        test_lsb_command();
        test_lsb_output();
        test_idle_release();
        finish_test();
    end
endmodule : tb_adc_serial_control_port
